// [gsp_cfg.svh]
// Constants of the serial register port: offsets, field bits, reset values.
// Assumes inclusion by the package and the port module of this folder.
// Overview of operation
// (R1) The device is only ever a slave; it never drives clock or select.
// (R2) A low chip select frames a transaction; high ends it.
// (R3) Serial output stays released while chip select is high.
// (R4) The master selects at most one slave at a time.
// (R5) Command and data bytes travel most significant bit first.
// (R6) Incoming serial data is sampled on each rising clock edge.
// (R7) Both ends change driven data on the falling clock edge.
// (R8) The master keeps the serial clock at or below 8 MHz.
// (R9) A transaction is a command byte plus one or more data bytes.
// (R10) Command bit seven chooses direction: one reads, zero writes.
// (R11) The other seven command bits give the register address.
// (R12) Single and burst transfers are accepted for reads and writes.
// (R13) An SPI master sets the two-wire port disable bit early after start-up.
// (R14) In a burst the register address steps up after every data byte.
// (R15) Reads return register contents from the byte after the command.
`ifndef GSP_CFG_SVH
`define GSP_CFG_SVH
`define GSP_ADDR_ST_X 7'h00
`define GSP_ADDR_ST_Y 7'h01
`define GSP_ADDR_ST_Z 7'h02
`define GSP_ADDR_XOFF_H 7'h13
`define GSP_ADDR_XOFF_L 7'h14
`define GSP_ADDR_YOFF_H 7'h15
`define GSP_ADDR_YOFF_L 7'h16
`define GSP_ADDR_ZOFF_H 7'h17
`define GSP_ADDR_ZOFF_L 7'h18
`define GSP_ADDR_RATE_DIV 7'h19
`define GSP_ADDR_FILT_CFG 7'h1A
`define GSP_ADDR_RANGE_CFG 7'h1B
`define GSP_ADDR_LP_CFG 7'h1E
`define GSP_ADDR_QSRC 7'h23
`define GSP_ADDR_FSYNC_STAT 7'h36
`define GSP_ADDR_INT_PIN_CFG 7'h37
`define GSP_ADDR_INT_EN 7'h38
`define GSP_ADDR_INT_FLAGS 7'h3A
`define GSP_ADDR_TEMP_H 7'h41
`define GSP_ADDR_TEMP_L 7'h42
`define GSP_ADDR_XRATE_H 7'h43
`define GSP_RW_COUNT 16
`define GSP_BANK_W 128
`define GSP_CMD_RW_BIT 7
`define GSP_FSYNC_BIT 7
`define GSP_OFLOW_BIT 4
`define GSP_GDRIVE_BIT 2
`define GSP_DRDY_BIT 0
`define GSP_ST_RESET 8'h40
`define GSP_REG_RESET 8'h00
`define GSP_LAST_BIT 3'h7
`endif

// [gsp_pkg.sv]
// Types of the serial register port: one state record per register group, three on the serial clock and one on clk_sys.
// Assumes gsp_cfg.svh is found on the include path.
`include "gsp_cfg.svh"
package gsp_pkg;
    typedef struct packed {
        logic [2:0] bitCnt;
        logic [6:0] shift;
        logic isRead;
        logic cmdSeen;
    } gsp_frame_t;
    typedef struct packed {
        logic [7:0] rxByte;
        logic rxIsCmd;
        logic rxTgl;
    } gsp_hold_t;
    typedef struct packed {
        logic [7:0] txShift;
        logic dout;
        logic oeN;
    } gsp_tx_t;
    typedef struct packed {
        logic [2:0] tglSync;
        logic tglSeen;
        logic [6:0] addr;
        logic isRead;
        logic [7:0] txByte;
        logic [7:0] fsyncStat;
        logic [7:0] intFlags;
        logic wrStb;
        logic [6:0] wrAddr;
        logic [7:0] wrData;
        logic [`GSP_BANK_W-1:0] bank;
    } gsp_sys_t;
endpackage

// [gsp_spi_port.sv]
// Four-wire serial slave port onto the internal register bank.
// Assumes the master keeps chip select high between transactions and
// that the rest of the device feeds events and samples on clk_sys.
`timescale 1ns/1ps
`include "gsp_cfg.svh"
module gsp_spi_port #(
    parameter logic [7:0] ST_X_CODE = `GSP_ST_RESET,
    parameter logic [7:0] ST_Y_CODE = `GSP_ST_RESET,
    parameter logic [7:0] ST_Z_CODE = `GSP_ST_RESET
) (
    // System clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial link from the master.
    input wire logic serialClockLine,
    input wire logic chipSelectN,
    input wire logic serialInLine,
    // Serial data output pin with active-low enable.
    output logic serialOutLine,
    output logic serialOutEnN,
    // Events from the sensor side.
    input wire logic fsyncEvent,
    input wire logic dataReadyEvent,
    input wire logic gdriveEvent,
    input wire logic overflowEvent,
    // Sample values shown in read-only registers, xRateValue by its high byte only.
    input wire logic [15:0] temperatureValue,
    input wire logic [15:0] xRateValue,
    // Register write notice to the rest of the device.
    output logic regWrStrobe,
    output logic [6:0] regWrAddr,
    output logic [7:0] regWrData,
    // Read-write register bank, entry zero in the low byte.
    output logic [`GSP_BANK_W-1:0] configBank
);
    import gsp_pkg::*;

    localparam logic [`GSP_BANK_W-1:0] BANK_RESET = {
        {(`GSP_BANK_W - 24){1'b0}}, ST_Z_CODE, ST_Y_CODE, ST_X_CODE
    };

    gsp_frame_t frame_q;
    gsp_frame_t frame_d;
    gsp_hold_t hold_q;
    gsp_hold_t hold_d;
    gsp_tx_t tx_q;
    gsp_tx_t tx_d;
    gsp_sys_t sys_q;
    gsp_sys_t sys_d;

    logic frameRst;
    logic rxEvent;
    logic [6:0] rdAddr;
    logic [7:0] rdValue;
    logic [4:0] wrSlot;
    logic [3:0] wrIdx;
    logic wrHit;
    logic doWrite;
    logic doRead;
    logic [`GSP_RW_COUNT-1:0] entryWr;

    // Maps an address onto the read-write bank entry it owns.
    function automatic logic [4:0] bankIndex(input logic [6:0] a);
        logic [4:0] r;
        r = 5'h00;
        case (a)
            `GSP_ADDR_ST_X: r = 5'h10;
            `GSP_ADDR_ST_Y: r = 5'h11;
            `GSP_ADDR_ST_Z: r = 5'h12;
            `GSP_ADDR_XOFF_H: r = 5'h13;
            `GSP_ADDR_XOFF_L: r = 5'h14;
            `GSP_ADDR_YOFF_H: r = 5'h15;
            `GSP_ADDR_YOFF_L: r = 5'h16;
            `GSP_ADDR_ZOFF_H: r = 5'h17;
            `GSP_ADDR_ZOFF_L: r = 5'h18;
            `GSP_ADDR_RATE_DIV: r = 5'h19;
            `GSP_ADDR_FILT_CFG: r = 5'h1A;
            `GSP_ADDR_RANGE_CFG: r = 5'h1B;
            `GSP_ADDR_LP_CFG: r = 5'h1C;
            `GSP_ADDR_QSRC: r = 5'h1D;
            `GSP_ADDR_INT_PIN_CFG: r = 5'h1E;
            `GSP_ADDR_INT_EN: r = 5'h1F;
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // Read value of any address; unmapped addresses read as zero.
    function automatic logic [7:0] readMux(
        input logic [6:0] a,
        input logic [`GSP_BANK_W-1:0] bank,
        input logic [7:0] fsyncStat,
        input logic [7:0] intFlags,
        input logic [15:0] temp,
        input logic [15:0] xRate
    );
        logic [4:0] idx;
        logic [7:0] v;
        idx = bankIndex(a);
        v = 8'h00;
        if (idx[4]) begin
            v = bank[idx[3:0]*8 +: 8];
        end else begin
            case (a)
                `GSP_ADDR_FSYNC_STAT: v = fsyncStat;
                `GSP_ADDR_INT_FLAGS: v = intFlags;
                `GSP_ADDR_TEMP_H: v = temp[15:8];
                `GSP_ADDR_TEMP_L: v = temp[7:0];
                `GSP_ADDR_XRATE_H: v = xRate[15:8];
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // (R2) Select framing: high select clears the frame.
    assign frameRst = chipSelectN | ~reset_n;

    // Link side, rising edge: shift in and count bits.
    always_comb begin
        frame_d = frame_q;
        frame_d.bitCnt = 3'(frame_q.bitCnt + 3'h1);
        // (R5) Msb first shifting.
        frame_d.shift = {frame_q.shift[5:0], serialInLine};
        // (R10) Direction bit capture.
        if (frame_q.bitCnt == 3'h0 && !frame_q.cmdSeen) begin
            frame_d.isRead = serialInLine;
        end
        // (R9) Command then data bytes.
        if (frame_q.bitCnt == `GSP_LAST_BIT) begin
            frame_d.cmdSeen = 1'b1;
        end
    end

    // (R6) Rising edge sampling.
    always_ff @(posedge serialClockLine or posedge frameRst) begin
        if (frameRst) begin
            frame_q <= '0;
        end else begin
            frame_q <= frame_d;
        end
    end

    // Link side, rising edge: hand each whole byte over with a toggle.
    always_comb begin
        hold_d = hold_q;
        if (frame_q.bitCnt == `GSP_LAST_BIT) begin
            hold_d.rxByte = {frame_q.shift, serialInLine};
            hold_d.rxIsCmd = ~frame_q.cmdSeen;
            hold_d.rxTgl = ~hold_q.rxTgl;
        end
    end

    // The toggle survives deselect so the system side sees no false edge.
    always_ff @(posedge serialClockLine or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_d;
        end
    end

    // Link side, falling edge: drive read data out.
    always_comb begin
        tx_d = tx_q;
        // (R7) Output changes on falling edge.
        tx_d.txShift = {tx_q.txShift[6:0], 1'b0};
        tx_d.dout = tx_q.txShift[7];
        // (R15) Load read byte after command.
        if (frame_q.bitCnt == 3'h0 && frame_q.cmdSeen && frame_q.isRead) begin
            tx_d.txShift = {sys_q.txByte[6:0], 1'b0};
            tx_d.dout = sys_q.txByte[7];
            tx_d.oeN = 1'b0;
        end
    end

    // (R3) Release output while deselected.
    always_ff @(negedge serialClockLine or posedge frameRst) begin
        if (frameRst) begin
            tx_q <= '{
                txShift: 8'h00,
                dout: 1'b0,
                oeN: 1'b1
            };
        end else begin
            tx_q <= tx_d;
        end
    end

    // System side: accept a byte once the synchronised toggle settles.
    assign rxEvent = (sys_q.tglSync[1] == sys_q.tglSync[2])
        && (sys_q.tglSync[2] != sys_q.tglSeen);
    // (R11) Command address bits.
    assign rdAddr = hold_q.rxIsCmd ? hold_q.rxByte[6:0] : sys_q.addr;
    assign rdValue = readMux(rdAddr, sys_q.bank, sys_q.fsyncStat,
        sys_q.intFlags, temperatureValue, xRateValue);
    assign doRead = rxEvent
        && (hold_q.rxIsCmd ? hold_q.rxByte[`GSP_CMD_RW_BIT] : sys_q.isRead);
    assign doWrite = rxEvent && !hold_q.rxIsCmd && !sys_q.isRead;
    // Bank slot of the current write address, split into hit and index.
    assign wrSlot = bankIndex(sys_q.addr);
    assign wrIdx = wrSlot[3:0];
    assign wrHit = wrSlot[4];

    // One write enable per bank entry.
    genvar gi;
    generate
        for (gi = 0; gi < `GSP_RW_COUNT; gi++) begin : g_entry
            assign entryWr[gi] = doWrite && wrHit && (wrIdx == 4'(gi));
        end
    endgenerate

    always_comb begin
        sys_d = sys_q;
        sys_d.tglSync = {sys_q.tglSync[1:0], hold_q.rxTgl};
        sys_d.wrStb = 1'b0;
        // Clear on read, then events set: a same-cycle event wins.
        if (doRead && rdAddr == `GSP_ADDR_FSYNC_STAT) begin
            sys_d.fsyncStat = 8'h00;
        end
        if (doRead && rdAddr == `GSP_ADDR_INT_FLAGS) begin
            sys_d.intFlags = 8'h00;
        end
        sys_d.fsyncStat[`GSP_FSYNC_BIT] =
            sys_d.fsyncStat[`GSP_FSYNC_BIT] | fsyncEvent;
        sys_d.intFlags[`GSP_OFLOW_BIT] =
            sys_d.intFlags[`GSP_OFLOW_BIT] | overflowEvent;
        sys_d.intFlags[`GSP_GDRIVE_BIT] =
            sys_d.intFlags[`GSP_GDRIVE_BIT] | gdriveEvent;
        sys_d.intFlags[`GSP_DRDY_BIT] =
            sys_d.intFlags[`GSP_DRDY_BIT] | dataReadyEvent;
        if (rxEvent) begin
            sys_d.tglSeen = sys_q.tglSync[2];
            // (R12) Single or burst, either direction.
            if (hold_q.rxIsCmd) begin
                sys_d.isRead = hold_q.rxByte[`GSP_CMD_RW_BIT];
                sys_d.addr = hold_q.rxByte[6:0];
            end
            // (R15) Fetch the next read byte.
            if (doRead) begin
                sys_d.txByte = rdValue;
                sys_d.addr = 7'(rdAddr + 7'h01);
            end
            // (R14) Write then step address.
            if (doWrite) begin
                sys_d.wrStb = 1'b1;
                sys_d.wrAddr = sys_q.addr;
                sys_d.wrData = hold_q.rxByte;
                sys_d.addr = 7'(sys_q.addr + 7'h01);
            end
        end
        for (int i = 0; i < `GSP_RW_COUNT; i++) begin
            if (entryWr[i]) begin
                sys_d.bank[i*8 +: 8] = hold_q.rxByte;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sys_q <= '{
                tglSync: 3'h0,
                tglSeen: 1'b0,
                addr: 7'h00,
                isRead: 1'b0,
                txByte: 8'h00,
                fsyncStat: `GSP_REG_RESET,
                intFlags: `GSP_REG_RESET,
                wrStb: 1'b0,
                wrAddr: 7'h00,
                wrData: 8'h00,
                bank: BANK_RESET
            };
        end else begin
            sys_q <= sys_d;
        end
    end

    // (R1) Only data out is driven; clock and select are inputs.
    assign serialOutLine = tx_q.dout;
    assign serialOutEnN = tx_q.oeN;
    assign regWrStrobe = sys_q.wrStb;
    assign regWrAddr = sys_q.wrAddr;
    assign regWrData = sys_q.wrData;
    assign configBank = sys_q.bank;

endmodule // gsp_spi_port

// [gsp_spi_props.sv]
// Checker of the serial register port, watching its top-level ports.
// Assumes a bind onto every instance of the port module.
`timescale 1ns/1ps
`include "gsp_cfg.svh"
module gsp_spi_props (
    // Clocks and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serialClockLine,
    // Link lines.
    input wire logic chipSelectN,
    input wire logic serialOutEnN,
    // Write notice and bank.
    input wire logic regWrStrobe,
    input wire logic [6:0] regWrAddr,
    input wire logic [7:0] regWrData,
    input wire logic [`GSP_BANK_W-1:0] configBank
);
    a_idle_released: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        chipSelectN && $past(chipSelectN) |-> serialOutEnN)
        else $error("Output driven while deselected.");
    a_drive_in_frame: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !serialOutEnN |-> !$past(chipSelectN))
        else $error("Output driven outside a frame.");
    a_link_drive: assert property (
        @(negedge serialClockLine) disable iff (!reset_n)
        !serialOutEnN |-> !chipSelectN)
        else $error("Output driven with select high.");
    a_strobe_single: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        regWrStrobe |=> !regWrStrobe [*8])
        else $error("Write strobe longer than one byte allows.");
    a_addr_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $changed(regWrAddr) |-> regWrStrobe)
        else $error("Write address moved without a write.");
    a_data_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $changed(regWrData) |-> regWrStrobe)
        else $error("Write data moved without a write.");
    a_bank_by_write: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        $changed(configBank) |-> regWrStrobe)
        else $error("Bank changed without a write.");
    a_rate_div_wr: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        regWrStrobe && regWrAddr == `GSP_ADDR_RATE_DIV
        |-> configBank[79:72] == regWrData)
        else $error("Rate divider not written.");
    a_ro_untouched: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        regWrStrobe && regWrAddr == `GSP_ADDR_TEMP_H |-> $stable(configBank))
        else $error("Read-only write changed the bank.");
endmodule // gsp_spi_props
bind gsp_spi_port gsp_spi_props chk_u (.clk_sys, .reset_n, .serialClockLine,
    .chipSelectN, .serialOutEnN, .regWrStrobe, .regWrAddr, .regWrData,
    .configBank);

// [gsp_spi_host.sv]
// Behavioural serial master driving frames into the register port.
// Assumes the bench fills wrBuf and calls frame; answers land in rdBuf.
`timescale 1ns/1ps
module gsp_spi_host (
    // Lines toward the device.
    output logic serialClockLine,
    output logic chipSelectN,
    output logic serialInLine,
    // Lines from the device.
    input wire logic serialOutLine,
    input wire logic serialOutEnN
);
    // Half period below the clock limit.
    localparam realtime HALF = 63.3;
    logic [7:0] wrBuf[8];
    logic [7:0] rdBuf[8];
    logic lineSeen;
    int oeErr = 0;
    // A released line reads as the inverse of its last value.
    assign lineSeen = serialOutEnN ? ~serialOutLine : serialOutLine;
    initial begin
        serialClockLine = 1'b0;
        chipSelectN = 1'b1;
        serialInLine = 1'b1;
    end
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [7:0] tx;
        chipSelectN = 1'b0;
        for (int b = 0; b <= n; b++) begin
            tx = (b == 0) ? cmd : wrBuf[b-1];
            for (int i = 7; i >= 0; i--) begin
                serialInLine = tx[i];
                #(HALF) serialClockLine = 1'b1;
                if (b > 0) rdBuf[b-1][i] = lineSeen;
                if (b > 0 && !cmd[7] && serialOutEnN === 1'b0) oeErr++;
                #(HALF) serialClockLine = 1'b0;
            end
        end
        chipSelectN = 1'b1;
        serialInLine = ~serialInLine;
        #(2 * HALF);
    endtask
endmodule // gsp_spi_host

// [tb_top.sv]
// Self-checking bench of the serial register port with a master model.
// Assumes gsp_cfg.svh on the include path.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, reset_n, sck, csN, serial_in_line, serial_out_line, oeN, wrStb;
    logic fsync, ready, gdrive, oflow;
    logic [15:0] temp, xRate;
    logic [6:0] wrAddr, a;
    logic [7:0] wrData, fsyncF, intF;
    logic [127:0] bank, mBank;
    int n_fail = 0, n_tests = 0, cyc = 0, n, seed;
    gsp_spi_port dut_u (.clk_sys, .reset_n, .serialClockLine(sck),
        .chipSelectN(csN), .serialInLine(serial_in_line), .serialOutLine(serial_out_line),
        .serialOutEnN(oeN), .fsyncEvent(fsync), .dataReadyEvent(ready),
        .gdriveEvent(gdrive), .overflowEvent(oflow),
        .temperatureValue(temp), .xRateValue(xRate), .regWrStrobe(wrStb),
        .regWrAddr(wrAddr), .regWrData(wrData), .configBank(bank));
    gsp_spi_host host_u (.serialClockLine(sck), .chipSelectN(csN),
        .serialInLine(serial_in_line), .serialOutLine(serial_out_line), .serialOutEnN(oeN));
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic int slot(input logic [6:0] r);
        case (r)
            7'h00, 7'h01, 7'h02: return r;
            7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19: return r - 16;
            7'h1A, 7'h1B: return r - 16;
            7'h1E: return 12;
            7'h23: return 13;
            7'h37, 7'h38: return r - 41;
            default: return -1;
        endcase
    endfunction
    function automatic logic [7:0] rdExp(input logic [6:0] r);
        case (r)
            7'h36: return fsyncF;
            7'h3A: return intF;
            7'h41: return temp[15:8];
            7'h42: return temp[7:0];
            7'h43: return xRate[15:8];
            default: return slot(r) < 0 ? 8'h00 : mBank[slot(r)*8 +: 8];
        endcase
    endfunction
    task automatic wrB(input logic [6:0] r, input int k);
        for (int i = 0; i < k; i++) begin
            host_u.wrBuf[i] = $random(seed);
            if (slot(r + i) >= 0) mBank[slot(r + i)*8 +: 8] = host_u.wrBuf[i];
        end
        host_u.frame({1'b0, r}, k);
        chk(bank, mBank);
        chk(wrAddr, 7'(r + k - 1));
        chk(wrData, host_u.wrBuf[k-1]);
        chk(oeN, 1'b1);
    endtask
    task automatic rdB(input logic [6:0] r, input int k);
        host_u.frame({1'b1, r}, k);
        for (int i = 0; i < k; i++) chk(host_u.rdBuf[i], rdExp(r + i));
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            final_report;
        end
    end
    initial begin
        seed = 32'h092480AE;
        clk_sys = 0;
        reset_n = 0;
        {fsync, ready, gdrive, oflow, temp, xRate} = '0;
        {fsyncF, intF} = '0;
        mBank = '0;
        mBank[23:0] = 24'h404040;
        repeat (12) @(negedge clk_sys);
        reset_n = 1;
        chk(bank, mBank);
        repeat (2) @(negedge clk_sys);
        host_u.wrBuf[0] = 8'h10;
        host_u.frame(8'h6A, 1);
        chk(bank, mBank);
        chk(wrAddr, 7'h6A);
        chk(wrData, 8'h10);
        for (int t = 0; t < 14; t++) begin
            @(negedge clk_sys);
            temp = $random(seed);
            xRate = $random(seed);
            a = $random(seed);
            n = 1 + ($random(seed) & 3);
            if (t % 2) rdB(a, n);
            else wrB(a, n);
        end
        wrB(7'h7F, 2);
        wrB(7'h41, 2);
        wrB(7'h18, 2);
        rdB(7'h7E, 4);
        rdB(7'h41, 3);
        @(negedge clk_sys);
        reset_n = 0;
        repeat (3) @(negedge clk_sys);
        mBank = '0;
        mBank[23:0] = 24'h404040;
        chk(bank, mBank);
        chk({wrStb, wrAddr, wrData, oeN}, 17'h00001);
        reset_n = 1;
        repeat (2) @(negedge clk_sys);
        {fsync, ready, gdrive, oflow} = 4'hF;
        @(negedge clk_sys);
        {fsync, ready, gdrive, oflow} = 4'h0;
        {fsyncF, intF} = 16'h8015;
        rdB(7'h36, 1);
        fsyncF = 8'h00;
        rdB(7'h36, 1);
        rdB(7'h3A, 1);
        intF = 8'h00;
        rdB(7'h3A, 1);
        chk(host_u.oeErr, 0);
        final_report;
    end
endmodule // tb_top
